// file: include/pamux_pkg.sv
`default_nettype none

package pamux_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int          NUM_PADS   = 8;
  localparam int          PAD_IDX_W  = 3;
  localparam int          NUM_ROUTED = 2;   // modules with several candidate pads
  localparam int          STAT_W     = NUM_PADS + 1;

  // pad roles (test port pads, nmi pad, wakeup pads)
  localparam int          TDI_PAD    = 0;   // port c bit 0
  localparam int          TDO_PAD    = 1;   // port c bit 1
  localparam int          TCK_PAD    = 2;   // port h bit 9
  localparam int          TMS_PAD    = 3;   // port h bit 10
  localparam int          NMI_PAD    = 5;
  localparam int          NMI_STAT_BIT = NUM_PADS;
  localparam logic [7:0]  WAKE_MASK  = 8'hC0;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] CFG_BASE   = 12'h000;  // one word per pad
  localparam logic [11:0] ISS_OFF    = 12'h040;  // input pad select fields
  localparam logic [11:0] GPO_OFF    = 12'h044;  // gpio output data
  localparam logic [11:0] GPI_OFF    = 12'h048;  // synchronised pad levels
  localparam logic [11:0] STAT_OFF   = 12'h04C;  // sticky events, write one to clear
  localparam logic [11:0] MASK_OFF   = 12'h050;
  localparam int          ISS_FLD_W  = 4;        // select field pitch in the word

  // ----------------------------------------------------------------
  // alternate function codes and pad configuration layout
  // ----------------------------------------------------------------
  localparam logic [1:0]  AF_ZERO    = 2'h0;     // general-purpose i/o
  localparam logic [1:0]  AF_TEST    = 2'h2;     // test port function
  localparam int          CFG_W      = 7;

  typedef struct packed {
    logic       nmi_sel;               // bit 6
    logic       pull_up;               // bit 5
    logic       pull_en;               // bit 4
    logic       obe;                   // bit 3, gpio output enable
    logic       input_buffer_enable;   // bit 2
    logic [1:0] alt_func_select;       // bits 1:0
  } pamux_cfg_s;

  typedef struct packed {
    logic out;
    logic oe;
    logic pull_en;
    logic pull_up;
  } pamux_drive_s;

  localparam pamux_cfg_s CFG_GPIO    = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, AF_ZERO};
  localparam pamux_cfg_s CFG_TEST_IN = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, AF_TEST};
  localparam pamux_cfg_s CFG_TEST_PU = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, AF_TEST};
  localparam pamux_cfg_s CFG_TEST_OUT = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, AF_TEST};

  // reset configuration of each pad
  function automatic pamux_cfg_s reset_cfg(input int idx);
    case (idx)
      TDI_PAD:          reset_cfg = CFG_TEST_IN;
      TDO_PAD:          reset_cfg = CFG_TEST_OUT;
      TCK_PAD, TMS_PAD: reset_cfg = CFG_TEST_PU;
      default:          reset_cfg = CFG_GPIO;
    endcase
  endfunction

endpackage

`default_nettype wire

// file: src/pamux_top.sv
// Functional notes
// - two-bit field picks output function zero..three
// - inputs reachable only with input buffer enabled; the GPI_OFF register reads synchronised pad levels ungated
// - function field steers outputs only, never inputs
// - inputs fan out; select fields pick pads
// - nmi selection overrides the function field
// - after reset pads are gpio except test
// - port c bits 0,1 reset to tdi,tdo
// - port h bits 9,10 reset tck,tms pulled up
// - tdo pad input, no pull, in standby
// - wakeup pads also raise external interrupts
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module pamux_top (
  // clock and reset
  input  wire  logic                                       hclk,
  input  wire  logic                                       hresetn,
  // ahb-lite slave
  input  wire  logic                                       hsel,
  input  wire  logic [31:0]                                haddr,
  input  wire  logic [1:0]                                 htrans,
  input  wire  logic                                       hwrite,
  input  wire  logic [2:0]                                 hsize,
  input  wire  logic [31:0]                                hwdata,
  input  wire  logic                                       hready,
  output logic       [31:0]                                hrdata,
  output logic                                             hreadyout,
  output logic                                             hresp,
  // package pads
  input  wire  logic [pamux_pkg::NUM_PADS-1:0]             pad_in,
  output logic       [pamux_pkg::NUM_PADS-1:0]             pad_out,
  output logic       [pamux_pkg::NUM_PADS-1:0]             pad_oe,
  output logic       [pamux_pkg::NUM_PADS-1:0]             pad_pull_en,
  output logic       [pamux_pkg::NUM_PADS-1:0]             pad_pull_up,
  // peripheral output functions one..three per pad
  input  wire  logic [pamux_pkg::NUM_PADS-1:0][3:1]        alt_data,
  input  wire  logic [pamux_pkg::NUM_PADS-1:0][3:1]        alt_oe,
  // power mode, asynchronous level
  input  wire  logic                                       standby,
  // peripheral inputs
  output logic       [pamux_pkg::NUM_PADS-1:0]             periph_in,
  output logic       [pamux_pkg::NUM_ROUTED-1:0]           routed_in,
  output logic                                             nmi_out,
  output logic       [pamux_pkg::NUM_PADS-1:0]             wakeup_out,
  output logic                                             irq
);

  localparam int N = pamux_pkg::NUM_PADS;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [N-1:0] pad_meta_r;
  logic [N-1:0] pad_sync_r;
  logic         stby_meta_r;
  logic         stby_r;

  // pad levels and standby are asynchronous to hclk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_meta_r  <= '0;
      pad_sync_r  <= '0;
      stby_meta_r <= 1'b0;
      stby_r      <= 1'b0;
    end else begin
      pad_meta_r  <= pad_in;
      pad_sync_r  <= pad_meta_r;
      stby_meta_r <= standby;
      stby_r      <= stby_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite slave front end
  // ----------------------------------------------------------------
  logic        addr_phase;
  logic        wr_pend_r;
  logic [11:0] wr_addr_r;
  logic [31:0] rd_mux;
  logic [31:0] hrdata_r;

  // every transfer completes with zero wait states and okay
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_r;
  assign addr_phase = hsel & hready & htrans[1];

  // writes land in the data phase, when hwdata stands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
    end else begin
      wr_pend_r <= addr_phase & hwrite;
      wr_addr_r <= haddr[11:0];
    end
  end

  function automatic logic wr_hit(input logic [11:0] off);
    wr_hit = wr_pend_r && (wr_addr_r == off);
  endfunction

  function automatic logic [11:0] cfg_addr(input int idx);
    cfg_addr = pamux_pkg::CFG_BASE + 12'(idx * 4);
  endfunction

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  pamux_pkg::pamux_cfg_s                                      cfg_r [N];
  logic [pamux_pkg::NUM_ROUTED-1:0][pamux_pkg::PAD_IDX_W-1:0] iss_r;
  logic [N-1:0]                                               gpo_r;
  logic [pamux_pkg::STAT_W-1:0]                               stat_r;
  logic [pamux_pkg::STAT_W-1:0]                               mask_r;
  logic [pamux_pkg::STAT_W-1:0]                               stat_ev;

  // pad configuration; test pads come up in their test function
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < N; i++) begin
        cfg_r[i] <= pamux_pkg::reset_cfg(i);
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if (wr_hit(cfg_addr(i))) begin
          cfg_r[i] <= hwdata[pamux_pkg::CFG_W-1:0];
        end
      end
    end
  end

  // input pad selects, gpio data and interrupt mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      iss_r  <= '0;
      gpo_r  <= '0;
      mask_r <= '0;
    end else begin
      for (int k = 0; k < pamux_pkg::NUM_ROUTED; k++) begin
        if (wr_hit(pamux_pkg::ISS_OFF)) begin
          iss_r[k] <= hwdata[k*pamux_pkg::ISS_FLD_W +: pamux_pkg::PAD_IDX_W];
        end
      end
      if (wr_hit(pamux_pkg::GPO_OFF)) begin
        gpo_r <= hwdata[N-1:0];
      end
      if (wr_hit(pamux_pkg::MASK_OFF)) begin
        mask_r <= hwdata[pamux_pkg::STAT_W-1:0];
      end
    end
  end

  // sticky status; an event in the clearing cycle survives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r <= '0;
    end else if (wr_hit(pamux_pkg::STAT_OFF)) begin
      stat_r <= (stat_r & ~hwdata[pamux_pkg::STAT_W-1:0]) | stat_ev;
    end else begin
      stat_r <= stat_r | stat_ev;
    end
  end

  // read data is fetched in the address phase and stands in the data phase
  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int i = 0; i < N; i++) begin
      if (haddr[11:0] == cfg_addr(i)) begin
        rd_mux[pamux_pkg::CFG_W-1:0] = cfg_r[i];
      end
    end
    for (int k = 0; k < pamux_pkg::NUM_ROUTED; k++) begin
      if (haddr[11:0] == pamux_pkg::ISS_OFF) begin
        rd_mux[k*pamux_pkg::ISS_FLD_W +: pamux_pkg::PAD_IDX_W] = iss_r[k];
      end
    end
    case (haddr[11:0])
      pamux_pkg::GPO_OFF:  rd_mux[N-1:0] = gpo_r;
      pamux_pkg::GPI_OFF:  rd_mux[N-1:0] = pad_sync_r;
      pamux_pkg::STAT_OFF: rd_mux[pamux_pkg::STAT_W-1:0] = stat_r;
      pamux_pkg::MASK_OFF: rd_mux[pamux_pkg::STAT_W-1:0] = mask_r;
      default: ;
    endcase
  end

  // unmapped addresses read as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata_r <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // output selection
  // ----------------------------------------------------------------
  pamux_pkg::pamux_drive_s drv [N];
  pamux_pkg::pamux_drive_s drv_r [N];

  // nmi first, then function field; standby parks tdo as a bare input
  always_comb begin
    for (int i = 0; i < N; i++) begin
      drv[i].pull_en = cfg_r[i].pull_en;
      drv[i].pull_up = cfg_r[i].pull_up;
      if (cfg_r[i].nmi_sel) begin
        drv[i].out = 1'b0;
        drv[i].oe  = 1'b0;
      end else if (cfg_r[i].alt_func_select == pamux_pkg::AF_ZERO) begin
        drv[i].out = gpo_r[i];
        drv[i].oe  = cfg_r[i].obe;
      end else begin
        drv[i].out = alt_data[i][cfg_r[i].alt_func_select];
        drv[i].oe  = alt_oe[i][cfg_r[i].alt_func_select];
      end
      if (i == pamux_pkg::TDO_PAD && stby_r) begin
        drv[i].oe      = 1'b0;
        drv[i].pull_en = 1'b0;
      end
    end
  end

  // pad controls leave from flip-flops so the pads see no glitches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < N; i++) begin
        drv_r[i] <= '{1'b0, 1'b0, 1'b0, 1'b0};
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        drv_r[i] <= drv[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      pad_out[i]     = drv_r[i].out;
      pad_oe[i]      = drv_r[i].oe;
      pad_pull_en[i] = drv_r[i].pull_en;
      pad_pull_up[i] = drv_r[i].pull_up;
    end
  end

  // ----------------------------------------------------------------
  // input routing and events
  // ----------------------------------------------------------------
  logic [N-1:0]                        gated;
  logic [N-1:0]                        gated_r;
  logic [N-1:0]                        gated_prev_r;
  logic [pamux_pkg::NUM_ROUTED-1:0]    routed_r;
  logic                                nmi_lvl;
  logic                                nmi_r;
  logic                                irq_r;

  // input path ignores the function field entirely
  always_comb begin
    for (int i = 0; i < N; i++) begin
      gated[i] = pad_sync_r[i] & cfg_r[i].input_buffer_enable;
    end
  end

  assign nmi_lvl = gated[pamux_pkg::NMI_PAD] & cfg_r[pamux_pkg::NMI_PAD].nmi_sel;

  // wakeup pads raise interrupt events on a rising level
  always_comb begin
    stat_ev = '0;
    stat_ev[N-1:0] = pamux_pkg::WAKE_MASK & gated & ~gated_prev_r;
    stat_ev[pamux_pkg::NMI_STAT_BIT] = nmi_lvl & ~nmi_r;
  end

  // every module sees every pad; selectors pick one candidate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gated_r      <= '0;
      gated_prev_r <= '0;
      routed_r     <= '0;
      nmi_r        <= 1'b0;
      irq_r        <= 1'b0;
    end else begin
      gated_r      <= gated;
      gated_prev_r <= gated;
      for (int k = 0; k < pamux_pkg::NUM_ROUTED; k++) begin
        routed_r[k] <= gated[iss_r[k]];
      end
      nmi_r <= nmi_lvl;
      irq_r <= |((stat_r | stat_ev) & mask_r);
    end
  end

  assign periph_in  = gated_r;
  assign routed_in  = routed_r;
  assign nmi_out    = nmi_r;
  assign wakeup_out = gated_r & pamux_pkg::WAKE_MASK;
  assign irq        = irq_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  localparam int P = 4;   // a plain functional pad used for checks
  localparam int W = 6;   // a wakeup pad used for checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence wake_edge_s;
    cfg_r[W].input_buffer_enable && !pad_sync_r[W] ##1
    cfg_r[W].input_buffer_enable && pad_sync_r[W];
  endsequence

  sequence wake_seen_s;
    ##1 stat_r[W] && wakeup_out[W];
  endsequence

  af_select_a : assert property (
    !cfg_r[P].nmi_sel && cfg_r[P].alt_func_select != pamux_pkg::AF_ZERO
    |=> pad_out[P] == $past(alt_data[P][cfg_r[P].alt_func_select]))
    else $error("alternate output not selected by field");

  gpio_path_a : assert property (
    !cfg_r[P].nmi_sel && cfg_r[P].alt_func_select == pamux_pkg::AF_ZERO
    |=> pad_out[P] == $past(gpo_r[P]) && pad_oe[P] == $past(cfg_r[P].obe))
    else $error("gpio path wrong for function zero");

  inbuf_gate_a : assert property (
    !cfg_r[P].input_buffer_enable |=> !periph_in[P])
    else $error("input reached module with buffer disabled");

  inbuf_pass_a : assert property (
    cfg_r[P].input_buffer_enable |=> periph_in[P] == $past(pad_sync_r[P]))
    else $error("enabled input not passed regardless of field");

  route_sel_a : assert property (
    1'b1 |=> routed_in[0] == $past(gated[iss_r[0]]))
    else $error("routed input not from selected pad");

  nmi_prio_a : assert property (
    cfg_r[pamux_pkg::NMI_PAD].nmi_sel |=> !pad_oe[pamux_pkg::NMI_PAD])
    else $error("pad driven while nmi selected");

  reset_cfg_a : assert property (
    $rose(hresetn) |-> cfg_r[P] == pamux_pkg::CFG_GPIO
      && cfg_r[pamux_pkg::TDI_PAD] == pamux_pkg::CFG_TEST_IN
      && cfg_r[pamux_pkg::TDO_PAD] == pamux_pkg::CFG_TEST_OUT
      && cfg_r[pamux_pkg::TCK_PAD] == pamux_pkg::CFG_TEST_PU
      && cfg_r[pamux_pkg::TMS_PAD] == pamux_pkg::CFG_TEST_PU)
    else $error("pad configuration wrong after reset");

  stby_tdo_a : assert property (
    stby_r |=> !pad_oe[pamux_pkg::TDO_PAD] && !pad_pull_en[pamux_pkg::TDO_PAD])
    else $error("tdo pad driven or pulled in standby");

  wake_irq_a : assert property (
    wake_edge_s |-> wake_seen_s)
    else $error("wakeup edge lost as interrupt event");

  drive_off_a : assert property (
    !cfg_r[P].nmi_sel && cfg_r[P].alt_func_select != pamux_pkg::AF_ZERO
      && !alt_oe[P][cfg_r[P].alt_func_select] |=> !pad_oe[P])
    else $error("pad driven by non-driving function");

  irq_level_a : assert property (
    (stat_r & mask_r) != '0 |=> irq)
    else $error("unmasked status without interrupt");

endmodule // pamux_top

`default_nettype wire

// file: verif/pamux_pad_model.sv
`timescale 1ns/10ps
`default_nettype none

module pamux_pad_model (
  // clock
  input  wire logic                           hclk,
  // pad controls from the mux
  input  wire logic [pamux_pkg::NUM_PADS-1:0] pad_out,
  input  wire logic [pamux_pkg::NUM_PADS-1:0] pad_oe,
  input  wire logic [pamux_pkg::NUM_PADS-1:0] pad_pull_en,
  input  wire logic [pamux_pkg::NUM_PADS-1:0] pad_pull_up,
  // board side drivers
  input  wire logic [pamux_pkg::NUM_PADS-1:0] ext_level,
  input  wire logic [pamux_pkg::NUM_PADS-1:0] ext_drive,
  // resolved pad levels
  output logic      [pamux_pkg::NUM_PADS-1:0] pad_in
);
  // ----------------------------------------------------------------
  // floating pads
  // ----------------------------------------------------------------
  logic [pamux_pkg::NUM_PADS-1:0] float_r = 8'h55;

  // an open pad flips every cycle so a stale level can never pass a check
  always @(posedge hclk) begin
    float_r <= ~float_r;
  end

  // ----------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------
  // mux driver wins, then the board, then the weak pull, else floating
  assign pad_in = (pad_oe & pad_out)
                | (~pad_oe & ext_drive & ext_level)
                | (~pad_oe & ~ext_drive & pad_pull_en & pad_pull_up)
                | (~pad_oe & ~ext_drive & ~pad_pull_en & float_r);
endmodule // pamux_pad_model

`default_nettype wire

// file: verif/pamux_top_tb.sv
`timescale 1ns/10ps
`default_nettype none

module pamux_top_tb;
  localparam int N = pamux_pkg::NUM_PADS;
  localparam logic [31:0] STAT = {20'h0_0000, pamux_pkg::STAT_OFF};
  localparam logic [31:0] MASK = {20'h0_0000, pamux_pkg::MASK_OFF};
  localparam logic [31:0] ISS  = {20'h0_0000, pamux_pkg::ISS_OFF};
  localparam logic [31:0] GPO  = {20'h0_0000, pamux_pkg::GPO_OFF};
  localparam logic [31:0] GPI  = {20'h0_0000, pamux_pkg::GPI_OFF};

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                                 hclk = 1'b0;
  logic                                 hresetn = 1'b0;
  logic                                 hsel = 1'b0;
  logic [31:0]                          haddr = 32'h0000_0000;
  logic [1:0]                           htrans = 2'h0;
  logic                                 hwrite = 1'b0;
  logic [31:0]                          hwdata = 32'h0000_0000;
  logic                                 hready;
  logic [31:0]                          hrdata;
  logic                                 hreadyout;
  logic                                 hresp;
  logic [N-1:0][3:1]                    alt_data = '0;
  logic [N-1:0][3:1]                    alt_oe = '0;
  logic                                 standby = 1'b0;
  logic [N-1:0]                         ext_level = '0;
  logic [N-1:0]                         ext_drive = 8'hE1;
  logic [N-1:0]                         pad_in;
  logic [N-1:0]                         pad_out;
  logic [N-1:0]                         pad_oe;
  logic [N-1:0]                         pad_pull_en;
  logic [N-1:0]                         pad_pull_up;
  logic [N-1:0]                         periph_in;
  logic [pamux_pkg::NUM_ROUTED-1:0]     routed_in;
  logic                                 nmi_out;
  logic [N-1:0]                         wakeup_out;
  logic                                 irq;
  logic [7:0]                           rst_cfg [8] = '{8'h06, 8'h02, 8'h36, 8'h36,
                                                        8'h00, 8'h00, 8'h00, 8'h00};
  logic [3:0]                           dat;
  int                                   error_cnt = 0;
  int                                   tests_run = 0;
  int                                   cyc = 0;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  always #10 hclk = ~hclk;

  // ----------------------------------------------------------------
  // design and board model
  // ----------------------------------------------------------------
  pamux_top dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en),
    .pad_pull_up(pad_pull_up), .alt_data(alt_data), .alt_oe(alt_oe),
    .standby(standby), .periph_in(periph_in), .routed_in(routed_in),
    .nmi_out(nmi_out), .wakeup_out(wakeup_out), .irq(irq)
  );

  pamux_pad_model pad_u (
    .hclk(hclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en),
    .pad_pull_up(pad_pull_up), .ext_level(ext_level), .ext_drive(ext_drive),
    .pad_in(pad_in)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] cfg_adr(input int i);
    return {20'h0_0000, pamux_pkg::CFG_BASE} + 32'(4 * i);
  endfunction

  task automatic summarize();
    $display("checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // a hang ends the run as a mismatch
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one single transfer; waits on ready in both phases, never on a fixed count
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0000_0000, r);
    chk(what, r, e);
  endtask

  // pad outputs lag a register write by one edge, inputs by three
  task automatic settle();
    repeat (4) @(posedge hclk);
  endtask

  // event already latched: masked, unmasked, then cleared by writing one
  task automatic irq_cycle(input logic [31:0] ev);
    rd_chk("status set", STAT, ev);
    chk("irq while masked", 32'(irq), 32'h0000_0000);
    wr(MASK, ev);
    settle();
    chk("irq unmasked", 32'(irq), 32'h0000_0001);
    wr(STAT, ev);
    settle();
    chk("irq cleared", 32'(irq), 32'h0000_0000);
    rd_chk("status cleared", STAT, 32'h0000_0000);
    wr(MASK, 32'h0000_0000);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge hclk);
    chk("ready in reset", 32'(hreadyout), 32'h0000_0001);
    hresetn <= 1'b1;
    // test pads 0..3 are never reassigned, so boundary scan stays usable
    for (int i = 0; i < N; i++) begin
      rd_chk("pad config", cfg_adr(i), {24'h00_0000, rst_cfg[i]});
    end
    chk("response", 32'(hresp), 32'h0000_0000);
    chk("pull enables", 32'(pad_pull_en), 32'h0000_000C);
    chk("pull ups", 32'(pad_pull_up), 32'h0000_000C);
    chk("drivers off", 32'(pad_oe), 32'h0000_0000);
    // tdo follows the test port; standby turns it into a plain input
    alt_oe[1][2] <= 1'b1;
    alt_data[1][2] <= 1'b1;
    settle();
    chk("tdo drive", 32'({pad_oe[1], pad_out[1]}), 32'h0000_0003);
    standby <= 1'b1;
    settle();
    chk("tdo standby", 32'({pad_oe[1], pad_pull_en[1]}), 32'h0000_0000);
    standby <= 1'b0;
    settle();
    chk("tdo after standby", 32'(pad_oe[1]), 32'h0000_0001);
    // every field code on pad 4, two data patterns; f2 keeps its enable low
    for (int d = 0; d < 2; d++) begin
      dat = d ? 4'b0101 : 4'b1010;
      alt_data[4] <= dat[3:1];
      alt_oe[4] <= 3'b101;
      wr(GPO, 32'(dat[0]) << 4);
      for (int f = 0; f < 4; f++) begin
        wr(cfg_adr(4), (f == 0) ? 32'h0000_0008 : 32'(f));
        settle();
        chk("pad4 enable", 32'(pad_oe[4]), 32'(f != 2));
        chk("pad4 level", 32'(pad_out[4] | (f == 2)), 32'(dat[f] | (f == 2)));
      end
    end
    // input gating by buffer enable across all field codes
    alt_oe[4] <= 3'b000;
    ext_drive[4] <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      ext_level[4] <= c[0];
      wr(cfg_adr(4), 32'(c[3:1]));
      settle();
      chk("pad4 input", 32'(periph_in[4]), 32'(c[3] & c[0]));
    end
    // select fields steer pads 4 and 7 both ways round
    wr(cfg_adr(7), 32'h0000_0004);
    for (int k = 0; k < 2; k++) begin
      wr(ISS, k ? 32'h0000_0047 : 32'h0000_0074);
      settle();
      chk("routed inputs", 32'(routed_in), k ? 32'h0000_0002 : 32'h0000_0001);
      chk("fanout inputs", 32'(periph_in & 8'h90), 32'h0000_0010);
    end
    wr(STAT, 32'h0000_01FF);
    // nmi selected with function one ready to drive
    alt_data[5] <= 3'b111;
    alt_oe[5] <= 3'b111;
    wr(cfg_adr(5), 32'h0000_0045);
    ext_level[5] <= 1'b1;
    settle();
    chk("nmi pad enable", 32'(pad_oe[5]), 32'h0000_0000);
    chk("nmi out", 32'(nmi_out), 32'h0000_0001);
    irq_cycle(32'h0000_0100);
    // wakeup pad edge reaches both wakeup and interrupt logic
    wr(cfg_adr(6), 32'h0000_0004);
    ext_level[6] <= 1'b1;
    settle();
    chk("wakeup out", 32'(wakeup_out), 32'h0000_0040);
    // every pad is driven or pulled now: 0 low, 1..6 high, 7 low
    rd_chk("pad levels", GPI, 32'h0000_007E);
    irq_cycle(32'h0000_0040);
    // unmapped place reads zero and a write there lands nowhere
    wr(32'h0000_0100, 32'hFFFF_FFFF);
    rd_chk("unmapped", 32'h0000_0100, 32'h0000_0000);
    rd_chk("mask kept", MASK, 32'h0000_0000);
    // second reset in mid-run restores defaults
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("pad4 after reset", cfg_adr(4), 32'h0000_0000);
    rd_chk("tck after reset", cfg_adr(2), 32'h0000_0036);
    summarize();
  end
endmodule // pamux_top_tb

`default_nettype wire
